//--- design/irq_signal.sv
// How it works
// - In Normal and Stop mode an interrupt drives the output low for the pulse width, then drives it high again.
// - The output stays high at least the minimum gap between two pulses.
// - Interrupt pulses never change the operating mode; mode is an input only.
// - Class select 0 (reset) gives wake-only interrupts, 1 adds failures.
// - A newly set wake status bit interrupts only if its wake source is enabled; the Stop entry check ignores the enables.
// - The bus timeout flag counts as a wake source governed only by its own mask.
// - In global class every enabled failure flag interrupts; wake level status never does.
// - Undervoltage, watchdog fail, supply short, thermal shutdown and failure flags selected by i_fail_fatal_sel never interrupt.
// - Power-on flag and device status bits never interrupt.
// - Entering Stop mode with any wake status bit set issues a pulse.
// - Visible status snapshots are updated at each falling edge of the pulse.
// - Latched events stay set until the controller clears them.
// - In Init mode the pin is an input for configuration select, filtered for 7 us.
`timescale 1ns/1ps
`default_nettype none
module irq_signal
    import irq_sig_pkg::*;
(
    input  wire logic              i_clk,
    input  wire logic              i_sys_rst,
    input  wire logic [2:0]        i_mode,
    input  wire logic              i_class_global,
    input  wire logic [WAKE_W-1:0] i_wake_status_a,
    input  wire logic [WAKE_W-1:0] i_wake_status_b,
    input  wire logic [WAKE_W-1:0] i_wake_en_a,
    input  wire logic [WAKE_W-1:0] i_wake_en_b,
    input  wire logic              i_bus_timeout_flag,
    input  wire logic              i_bus_timeout_irq_mask,
    input  wire logic [FAIL_W-1:0] i_fail_status,
    input  wire logic [FAIL_W-1:0] i_fail_fatal_sel,
    input  wire logic              i_irq_pin_in,
    output logic                   o_irq_pin_out,
    output logic                   o_irq_pin_oe_n,
    output logic                   o_cfg_select,
    output logic                   o_status_update,
    output logic [WAKE_W-1:0]      o_wake_status_a_vis,
    output logic [WAKE_W-1:0]      o_wake_status_b_vis,
    output logic                   o_bus_timeout_vis,
    output logic [FAIL_W-1:0]      o_fail_status_vis
);
    irq_st_e          st_r;
    logic [CNT_W-1:0] cnt_r;
    logic             pend_r;
    logic [2:0]       mode_r;
    logic [WAKE_W-1:0] wa_r;
    logic [WAKE_W-1:0] wb_r;
    logic             to_r;
    logic [FAIL_W-1:0] fl_r;
    logic             active;
    logic             init_mode;
    logic             rise;
    logic             stop_entry;
    logic             fire;
    logic [FAIL_W-1:0] fail_ok;

    assign active    = (i_mode == MODE_NORMAL) || (i_mode == MODE_STOP);
    assign init_mode = (i_mode == MODE_INIT);
    // Fatal flags, power-on and device status are kept off the fail vector by the mask
    assign fail_ok   = i_fail_status & ~i_fail_fatal_sel;

    // -----------------------------------------------------------------
    // Event detection
    // -----------------------------------------------------------------
    always_comb begin
        rise = |(i_wake_status_a & i_wake_en_a & ~wa_r)
             | |(i_wake_status_b & i_wake_en_b & ~wb_r)
             | (i_bus_timeout_flag & ~i_bus_timeout_irq_mask & ~to_r)
             | (i_class_global & |(fail_ok & ~fl_r));
    end
    assign stop_entry = (i_mode == MODE_STOP) && (mode_r != MODE_STOP)
                        && (|i_wake_status_a || |i_wake_status_b);

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            wa_r   <= '0;
            wb_r   <= '0;
            to_r   <= 1'b0;
            fl_r   <= '0;
            mode_r <= MODE_INIT;
        end else begin
            wa_r   <= i_wake_status_a & i_wake_en_a;
            wb_r   <= i_wake_status_b & i_wake_en_b;
            to_r   <= i_bus_timeout_flag & ~i_bus_timeout_irq_mask;
            fl_r   <= fail_ok;
            mode_r <= i_mode;
        end
    end

    // -----------------------------------------------------------------
    // Pending request, set wins over consume
    // -----------------------------------------------------------------
    assign fire = (st_r == ST_IDLE) && active && (pend_r || rise || stop_entry);

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            pend_r <= 1'b0;
        end else if (!active) begin
            pend_r <= 1'b0;
        end else if (st_r != ST_IDLE && (rise || stop_entry)) begin
            pend_r <= 1'b1;
        end else if (fire) begin
            pend_r <= 1'b0;
        end
    end

    // -----------------------------------------------------------------
    // Pulse and gap sequencer
    // -----------------------------------------------------------------
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            st_r  <= ST_IDLE;
            cnt_r <= '0;
        end else begin
            case (st_r)
                ST_IDLE: begin
                    cnt_r <= '0;
                    if (fire) begin
                        st_r <= ST_PULSE;
                    end
                end
                ST_PULSE: begin
                    if (cnt_r == CNT_W'(PULSE_CYC - 1)) begin
                        cnt_r <= '0;
                        st_r  <= ST_GAP;
                    end else begin
                        cnt_r <= cnt_r + 1'b1;
                    end
                end
                ST_GAP: begin
                    if (cnt_r == CNT_W'(GAP_CYC - 1)) begin
                        cnt_r <= '0;
                        st_r  <= ST_IDLE;
                    end else begin
                        cnt_r <= cnt_r + 1'b1;
                    end
                end
                default: begin
                    st_r  <= ST_IDLE;
                    cnt_r <= '0;
                end
            endcase
        end
    end

    // Pin driven low during pulse, high otherwise; released in Init mode
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_irq_pin_out  <= 1'b1;
            o_irq_pin_oe_n <= 1'b1;
        end else begin
            o_irq_pin_out  <= !fire && !(st_r == ST_PULSE && cnt_r != CNT_W'(PULSE_CYC - 1));
            o_irq_pin_oe_n <= init_mode;
        end
    end

    // -----------------------------------------------------------------
    // Visible status snapshot at the falling edge
    // -----------------------------------------------------------------
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_status_update     <= 1'b0;
            o_wake_status_a_vis <= '0;
            o_wake_status_b_vis <= '0;
            o_bus_timeout_vis   <= 1'b0;
            o_fail_status_vis   <= '0;
        end else begin
            o_status_update <= fire;
            if (fire) begin
                o_wake_status_a_vis <= i_wake_status_a;
                o_wake_status_b_vis <= i_wake_status_b;
                o_bus_timeout_vis   <= i_bus_timeout_flag;
                o_fail_status_vis   <= i_fail_status;
            end
        end
    end

    irq_cfg_filter u_cfg_filter (
        .i_clk     (i_clk),
        .i_sys_rst (i_sys_rst),
        .i_raw     (i_irq_pin_in),
        .i_en      (init_mode),
        .o_level   (o_cfg_select)
    );

    // -----------------------------------------------------------------
    // Checks
    // -----------------------------------------------------------------
    pulse_width_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        $fell(o_irq_pin_out) |-> !o_irq_pin_out [*8])
        else $error("irq pulse shorter than expected");
    // Counts consecutive low cycles of the pin, saturating
    logic [CNT_W-1:0] low_cnt_r;

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            low_cnt_r <= '0;
        end else if (o_irq_pin_out) begin
            low_cnt_r <= '0;
        end else if (low_cnt_r != '1) begin
            low_cnt_r <= low_cnt_r + 1'b1;
        end
    end

    pulse_end_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        !o_irq_pin_out |-> (low_cnt_r < CNT_W'(PULSE_CYC)))
        else $error("irq pulse did not end");
    gap_hold_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (st_r == ST_GAP) |-> o_irq_pin_out)
        else $error("irq low during gap");
    idle_mode_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        !active |-> !fire)
        else $error("irq fired outside normal or stop");
    stop_entry_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        stop_entry |-> ##1 (st_r == ST_PULSE || pend_r))
        else $error("stop entry lost interrupt");
    pend_keep_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (pend_r && active && st_r != ST_IDLE) |=> pend_r)
        else $error("pending request dropped");
    snap_edge_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        $fell(o_irq_pin_out) |-> o_status_update)
        else $error("status not updated at falling edge");
    init_release_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        init_mode |=> o_irq_pin_oe_n)
        else $error("pin driven in init mode");
    wake_class_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (!i_class_global && st_r == ST_IDLE && active && !pend_r && !stop_entry
         && i_wake_status_a == wa_r && i_wake_status_b == wb_r && !(i_bus_timeout_flag && !to_r))
        |-> !fire)
        else $error("failure raised irq in wake class");
endmodule : irq_signal
`default_nettype wire

//--- design/irq_sig_pkg.sv
package irq_sig_pkg;

    // -----------------------------------------------------------------
    // Clock and timing
    // -----------------------------------------------------------------
    localparam int CLK_MHZ                 = 50;
    localparam int IRQ_PULSE_WIDTH_US      = 100;
    localparam int IRQ_MIN_GAP_US          = 100;
    localparam int CFG_SELECT_FILTER_US    = 7;
    localparam int PULSE_CYC               = IRQ_PULSE_WIDTH_US * CLK_MHZ;
    localparam int GAP_CYC                 = IRQ_MIN_GAP_US * CLK_MHZ;
    localparam int CFG_FILT_CYC            = CFG_SELECT_FILTER_US * CLK_MHZ;
    localparam int CNT_W                   = 13;

    // -----------------------------------------------------------------
    // Field widths and reset values
    // -----------------------------------------------------------------
    localparam int WAKE_W                  = 8;
    localparam int FAIL_W                  = 16;
    localparam logic RST_CLASS_GLOBAL      = 1'b0;

    // -----------------------------------------------------------------
    // Operating modes
    // -----------------------------------------------------------------
    typedef enum logic [2:0] {
        MODE_INIT     = 3'h0,
        MODE_NORMAL   = 3'h1,
        MODE_STOP     = 3'h2,
        MODE_SLEEP    = 3'h3,
        MODE_RESTART  = 3'h4,
        MODE_FAILSAFE = 3'h5
    } op_mode_e;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'h0,
        ST_PULSE = 2'h1,
        ST_GAP   = 2'h2
    } irq_st_e;

endpackage : irq_sig_pkg

//--- design/irq_cfg_filter.sv
`timescale 1ns/1ps
`default_nettype none
module irq_cfg_filter
    import irq_sig_pkg::*;
(
    input  wire logic i_clk,
    input  wire logic i_sys_rst,
    input  wire logic i_raw,
    input  wire logic i_en,
    output logic      o_level
);
    logic             s1_r;
    logic             s2_r;
    logic [CNT_W-1:0] cnt_r;

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
        end else begin
            s1_r <= i_raw;
            s2_r <= s1_r;
        end
    end

    // Level is taken only after standing stable for the filter time
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            cnt_r   <= '0;
            o_level <= 1'b0;
        end else if (!i_en || s2_r == o_level) begin
            cnt_r <= '0;
        end else if (cnt_r == CNT_W'(CFG_FILT_CYC - 1)) begin
            cnt_r   <= '0;
            o_level <= s2_r;
        end else begin
            cnt_r <= cnt_r + 1'b1;
        end
    end
endmodule : irq_cfg_filter
`default_nettype wire

//--- testbench/host_mcu.sv
`timescale 1ns/1ps
`default_nettype none
module host_mcu (
    input  wire logic        i_clk,
    input  wire logic        i_sys_rst,
    input  wire logic [15:0] i_set,
    input  wire logic        i_clear,
    input  wire logic        i_cfg_level,
    input  wire logic        i_pin_out,
    input  wire logic        i_oe_n,
    output logic      [15:0] o_wake_st,
    output logic             o_pin
);
    // ----------------------------------------------
    // Latched wake flags and pin level
    // ----------------------------------------------
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_wake_st <= 16'h0000;
        end else if (i_clear) begin
            o_wake_st <= i_set;
        end else begin
            o_wake_st <= o_wake_st | i_set;
        end
    end
    // Config strap drives the pin only while the device leaves it
    assign o_pin = i_oe_n ? i_cfg_level : i_pin_out;
endmodule : host_mcu
`default_nettype wire

//--- testbench/tb_irq_signal.sv
`timescale 1ns/1ps
`default_nettype none
module tb_irq_signal;
    import irq_sig_pkg::*;
    logic        i_clk, i_sys_rst, i_class_global, i_bus_timeout_flag, i_bus_timeout_irq_mask;
    logic        clr, cfg_lvl;
    logic [2:0]  i_mode;
    logic [15:0] set_req, en, fail, fatal;
    wire  logic [15:0] wst, fail_vis;
    wire  logic [7:0]  vis_a, vis_b;
    wire  logic        pin, pin_out, oe_n, cfg_sel, upd, bto_vis;
    int          mismatches, comparisons, hi;

    irq_signal irq_signal_i (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_mode(i_mode),
        .i_class_global(i_class_global), .i_wake_status_a(wst[7:0]), .i_wake_status_b(wst[15:8]),
        .i_wake_en_a(en[7:0]), .i_wake_en_b(en[15:8]), .i_bus_timeout_flag(i_bus_timeout_flag),
        .i_bus_timeout_irq_mask(i_bus_timeout_irq_mask), .i_fail_status(fail),
        .i_fail_fatal_sel(fatal), .i_irq_pin_in(pin), .o_irq_pin_out(pin_out),
        .o_irq_pin_oe_n(oe_n), .o_cfg_select(cfg_sel), .o_status_update(upd),
        .o_wake_status_a_vis(vis_a), .o_wake_status_b_vis(vis_b),
        .o_bus_timeout_vis(bto_vis), .o_fail_status_vis(fail_vis));
    host_mcu host_mcu_i (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_set(set_req), .i_clear(clr),
        .i_cfg_level(cfg_lvl), .i_pin_out(pin_out), .i_oe_n(oe_n), .o_wake_st(wst), .o_pin(pin));

    // ----------------------------------------------
    // Shared tasks
    // ----------------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask : tick
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task automatic pulse_set(input logic [15:0] v);
        set_req = v;
        tick(1);
        set_req = 16'h0000;
    endtask : pulse_set
    task automatic expect_none(input int n);
        logic seen;
        seen = 1'b0;
        repeat (n) begin
            tick(1);
            if (pin_out !== 1'b1) seen = 1'b1;
        end
        check(seen, 1'b0);
    endtask : expect_none
    // Waits for a fall, then measures the low time and update strobes
    task automatic expect_pulse(input int bound, output int h);
        int lo, up;
        h = 0; lo = 0; up = 0;
        while (pin_out === 1'b1 && h < bound) begin
            tick(1);
            h++;
        end
        while (pin_out === 1'b0 && lo < 6000) begin
            if (upd === 1'b1) up++;
            if (oe_n !== 1'b0) up += 100;
            tick(1);
            lo++;
        end
        check(lo, PULSE_CYC);
        check(up, 1);
    endtask : expect_pulse
    task automatic report_and_stop;
        $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : report_and_stop

    // ----------------------------------------------
    // Scenarios
    // ----------------------------------------------
    task automatic t_init;
        check({pin_out, oe_n}, 2'b11);
        cfg_lvl = 1'b1;
        tick(CFG_FILT_CYC + 10);
        check(cfg_sel, 1'b1);
        i_mode = MODE_NORMAL;
        tick(3);
        check({pin_out, oe_n}, 2'b10);
        $display("t_init done");
    endtask : t_init
    task automatic t_wake;
        en = 16'h0801;
        pulse_set(16'h0001);
        fork
            expect_pulse(10, hi);
            begin
                tick(6);
                pulse_set(16'h0800);
            end
        join
        check(vis_a, 8'h01);
        expect_pulse(GAP_CYC + 10, hi);
        check(hi >= GAP_CYC, 1'b1);
        check(vis_b, 8'h08);
        expect_none(GAP_CYC + 20);
        clr = 1'b1;
        tick(1);
        clr = 1'b0;
        tick(1);
        check(wst, 16'h0000);
        $display("t_wake done");
    endtask : t_wake
    task automatic t_class;
        en = 16'h0000;
        pulse_set(16'h0002);
        expect_none(20);
        fail = 16'h0004;
        expect_none(20);
        fail = 16'h0000;
        i_class_global = 1'b1;
        fatal = 16'h0020;
        tick(2);
        fail = 16'h0020;
        expect_none(20);
        fail = 16'h0024;
        expect_pulse(10, hi);
        check(fail_vis, 16'h0024);
        tick(GAP_CYC + 10);
        fail = 16'h0000;
        i_class_global = 1'b0;
        i_bus_timeout_flag = 1'b1;
        expect_none(20);
        i_bus_timeout_flag = 1'b0;
        i_bus_timeout_irq_mask = 1'b0;
        tick(2);
        i_bus_timeout_flag = 1'b1;
        expect_pulse(10, hi);
        check(bto_vis, 1'b1);
        tick(GAP_CYC + 10);
        i_bus_timeout_flag = 1'b0;
        $display("t_class done");
    endtask : t_class
    task automatic t_stop;
        en = 16'h0001;
        i_mode = MODE_SLEEP;
        tick(2);
        clr = 1'b1;
        pulse_set(16'h0001);
        clr = 1'b0;
        expect_none(3);
        i_mode = MODE_NORMAL;
        expect_none(20);
        i_mode = MODE_STOP;
        expect_pulse(10, hi);
        $display("t_stop done");
    endtask : t_stop

    initial begin
        i_clk = 1'b0;
        forever #10 i_clk = ~i_clk;
    end
    initial begin
        #1800000;
        mismatches++;
        report_and_stop();
    end
    initial begin
        mismatches = 0; comparisons = 0;
        i_sys_rst = 1'b1; i_mode = MODE_INIT; i_class_global = 1'b0; clr = 1'b0; cfg_lvl = 1'b0;
        i_bus_timeout_flag = 1'b0; i_bus_timeout_irq_mask = 1'b1;
        set_req = 16'h0000; en = 16'h0000; fail = 16'h0000; fatal = 16'h0000;
        repeat (16) @(posedge i_clk);
        #1;
        i_sys_rst = 1'b0;
        tick(1);
        t_init();
        t_wake();
        t_class();
        t_stop();
        report_and_stop();
    end
endmodule : tb_irq_signal
`default_nettype wire
